// ### hw/start_trig_pkg.sv
// Constants for the start-condition trigger block.
// Assumes a 125 MHz system clock; bus pins are sampled asynchronously.
`default_nettype none
package start_trig_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // Start hold time (SDA low to SCL low) in nanoseconds
  localparam int unsigned HOLD_NS = 4000;
  localparam int unsigned HOLD_CYC_I = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [11:0] HOLD_CYC = 12'(HOLD_CYC_I);
  // Setup time before a repeated start (SCL high to SDA low)
  localparam int unsigned SETUP_NS = 4700;
  localparam int unsigned SETUP_CYC_I = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [11:0] SETUP_CYC = 12'(SETUP_CYC_I);
  // Bus-free time after a stop before a new start may begin
  localparam int unsigned FREE_NS = 4700;
  localparam int unsigned FREE_CYC_I = (FREE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [11:0] FREE_CYC = 12'(FREE_CYC_I);
  localparam logic TRIG_RESET = 1'b0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic BUSY_RESET = 1'b0;
endpackage
`default_nettype wire

// ### hw/bus_sync.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is not in the ref_clk_in domain.
`timescale 1ns/1ps
`default_nettype none
module bus_sync (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // Idle bus level is high
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule // bus_sync
`default_nettype wire

// ### hw/start_trig.sv
// Start-condition trigger: issues start or repeated start as bus master.
// Assumes the rest of the controller drives SCL/SDA outside start phases
// and reports wait state, arbitration loss and master status.
//
// Summary of operation
// - With the trigger at zero no start condition is produced, except a repeated start already under way when arbitration is lost.
// - With the trigger set and the bus free, SDA falls while SCL high.
// - After the hold time SCL is pulled low and the wait state entered.
// - A busy bus with reservation on holds the trigger as a reservation.
// - A pending reservation issues a start once the bus-free time after a stop has elapsed.
// - Reservation off, bus busy with another master, no master wait: a set flags and clears the trigger.
// - In master wait a set trigger restarts once the wait ends.
// - Arbitration loss clears the trigger.
// - Issuing the start as master clears the trigger.
// - Exit request, interface disable or reset clear the trigger.
// - The trigger reads as zero once the data has been set; this block has no data input and start_trigger_out always shows trig_reg.
`timescale 1ns/1ps
`default_nettype none
module start_trig (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic start_trigger_set_in,
  input wire logic start_clear_flag_clr_in,
  input wire logic reservation_disable_in,
  input wire logic exit_comm_request_in,
  input wire logic interface_enable_in,
  input wire logic master_wait_in,
  input wire logic wait_release_in,
  input wire logic arb_lost_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n_out,
  output logic sda_out,
  output logic sda_oe_n_out,
  output logic start_trigger_out,
  output logic start_clear_flag_out,
  output logic bus_busy_out,
  output logic start_done_out,
  output logic wait_state_out
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FREE = 3'b001,
    ST_SDA_LOW = 3'b010,
    ST_WAIT = 3'b011,
    ST_RS_SDA = 3'b100,
    ST_RS_SCL = 3'b101
  } state_e;

  logic scl_s;
  logic sda_s;
  logic scl_d_reg;
  logic scl_d_next;
  logic sda_d_reg;
  logic sda_d_next;
  logic start_det;
  logic stop_det;

  bus_sync u_scl_sync (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .async_in(scl_in),
    .sync_out(scl_s)
  );

  bus_sync u_sda_sync (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .async_in(sda_in),
    .sync_out(sda_s)
  );

  state_e state_reg;
  state_e state_next;
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  logic trig_reg;
  logic trig_next;
  logic flag_reg;
  logic flag_next;
  logic busy_reg;
  logic busy_next;
  logic own_reg;
  logic own_next;
  logic scl_reg;
  logic scl_next;
  logic sda_reg;
  logic sda_next;
  logic done_reg;
  logic done_next;
  logic wait_reg;
  logic wait_next;
  logic kill;
  logic go_start;

  assign start_det = scl_d_reg & scl_s & sda_d_reg & ~sda_s;
  assign stop_det = scl_d_reg & scl_s & ~sda_d_reg & sda_s;
  assign kill = exit_comm_request_in | ~interface_enable_in | arb_lost_in;

  always_comb begin
    scl_d_next = scl_s;
    sda_d_next = sda_s;
    state_next = state_reg;
    cnt_next = cnt_reg;
    trig_next = trig_reg;
    flag_next = flag_reg;
    busy_next = busy_reg;
    own_next = own_reg;
    scl_next = scl_reg;
    sda_next = sda_reg;
    done_next = 1'b0;
    wait_next = wait_reg;
    go_start = 1'b0;
    // Bus activity tracking for foreign masters
    if (start_det && !own_reg) begin
      busy_next = 1'b1;
    end
    if (stop_det) begin
      busy_next = 1'b0;
      own_next = 1'b0;
    end
    if (start_trigger_set_in) begin
      if (busy_reg && !own_reg && !master_wait_in &&
          reservation_disable_in) begin
        flag_next = 1'b1;
        trig_next = 1'b0;
      end else begin
        trig_next = 1'b1;
      end
    end else if (start_clear_flag_clr_in) begin
      flag_next = 1'b0;
    end
    unique case (state_reg)
      ST_IDLE: begin
        scl_next = 1'b1;
        sda_next = 1'b1;
        if (!busy_reg && scl_s && sda_s) begin
          state_next = ST_FREE;
          cnt_next = start_trig_pkg::FREE_CYC;
        end
      end
      ST_FREE: begin
        if (busy_reg || !scl_s || !sda_s) begin
          state_next = ST_IDLE;
        end else if (cnt_reg != 12'h000) begin
          cnt_next = cnt_reg - 12'h001;
        end else if (trig_reg && !kill) begin
          go_start = 1'b1;
        end
        if (go_start) begin
          sda_next = 1'b0;
          state_next = ST_SDA_LOW;
          cnt_next = start_trig_pkg::HOLD_CYC;
          busy_next = 1'b1;
          own_next = 1'b1;
        end
      end
      ST_SDA_LOW: begin
        if (cnt_reg != 12'h000) begin
          cnt_next = cnt_reg - 12'h001;
        end else begin
          scl_next = 1'b0;
          state_next = ST_WAIT;
          wait_next = 1'b1;
          trig_next = 1'b0;
          done_next = 1'b1;
        end
      end
      ST_WAIT: begin
        if (wait_release_in) begin
          wait_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      ST_RS_SDA: begin
        sda_next = 1'b1;
        if (scl_s) begin
          if (cnt_reg != 12'h000) begin
            cnt_next = cnt_reg - 12'h001;
          end else begin
            sda_next = 1'b0;
            state_next = ST_SDA_LOW;
            cnt_next = start_trig_pkg::HOLD_CYC;
          end
        end
      end
      ST_RS_SCL: begin
        scl_next = 1'b1;
        state_next = ST_RS_SDA;
        cnt_next = start_trig_pkg::SETUP_CYC;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Repeated start from the master wait state
    if ((state_reg == ST_IDLE || state_reg == ST_WAIT) && own_reg &&
        master_wait_in && wait_release_in && trig_reg && !kill) begin
      state_next = ST_RS_SCL;
      sda_next = 1'b1;
      wait_next = 1'b0;
    end
    if (kill) begin
      trig_next = 1'b0;
      if (exit_comm_request_in || !interface_enable_in) begin
        state_next = ST_IDLE;
        scl_next = 1'b1;
        sda_next = 1'b1;
        own_next = 1'b0;
        wait_next = 1'b0;
      end
    end
    if (!interface_enable_in) begin
      busy_next = 1'b0;
      flag_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= ST_IDLE;
      cnt_reg <= 12'h000;
      trig_reg <= start_trig_pkg::TRIG_RESET;
      flag_reg <= start_trig_pkg::FLAG_RESET;
      busy_reg <= start_trig_pkg::BUSY_RESET;
      own_reg <= 1'b0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      done_reg <= 1'b0;
      wait_reg <= 1'b0;
    end else begin
      scl_d_reg <= scl_d_next;
      sda_d_reg <= sda_d_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      trig_reg <= trig_next;
      flag_reg <= flag_next;
      busy_reg <= busy_next;
      own_reg <= own_next;
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      done_reg <= done_next;
      wait_reg <= wait_next;
    end
  end

  // Open drain: enable low only while pulling low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n_out = scl_reg;
  assign sda_oe_n_out = sda_reg;
  assign start_trigger_out = trig_reg;
  assign start_clear_flag_out = flag_reg;
  assign bus_busy_out = busy_reg;
  assign start_done_out = done_reg;
  assign wait_state_out = wait_reg;
endmodule // start_trig
`default_nettype wire

// ### tb/start_trig_props.sv
// Checker for the start trigger block.
// Bound to start_trig; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module start_trig_props (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic start_trigger_set_in,
  input wire logic reservation_disable_in,
  input wire logic exit_comm_request_in,
  input wire logic interface_enable_in,
  input wire logic master_wait_in,
  input wire logic wait_release_in,
  input wire logic arb_lost_in,
  input wire logic sda_oe_n_out,
  input wire logic scl_oe_n_out,
  input wire logic start_trigger_out,
  input wire logic start_clear_flag_out,
  input wire logic bus_busy_out,
  input wire logic start_done_out
);
  // Restart deadline in cycles: setup, hold and sync delay with margin
  localparam logic [10:0] RS_LIM = 11'h4b0;
  logic [10:0] rs_cnt_reg;
  logic [10:0] rs_cnt_next;
  // Cycles since a released master wait with the trigger pending
  always_comb begin
    rs_cnt_next = rs_cnt_reg;
    if (start_done_out || !start_trigger_out) begin
      rs_cnt_next = 11'h000;
    end else if (rs_cnt_reg != 11'h000) begin
      if (rs_cnt_reg != RS_LIM) begin
        rs_cnt_next = rs_cnt_reg + 11'h001;
      end
    end else if (wait_release_in && master_wait_in) begin
      rs_cnt_next = 11'h001;
    end
  end
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rs_cnt_reg <= 11'h000;
    end else begin
      rs_cnt_reg <= rs_cnt_next;
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence freed_s;
    $fell(bus_busy_out) ##0 start_trigger_out;
  endsequence
  no_idle_start_a: assert property ($fell(sda_oe_n_out) |->
    $past(start_trigger_out)) else $error("start without trigger");
  scl_high_a: assert property ($fell(sda_oe_n_out) |->
    scl_oe_n_out) else $error("sda fell with scl low");
  done_state_a: assert property (start_done_out |->
    !scl_oe_n_out && !start_trigger_out) else $error("bad done state");
  refuse_a: assert property (start_trigger_set_in && bus_busy_out &&
    reservation_disable_in && interface_enable_in && !master_wait_in |=>
    start_clear_flag_out && !start_trigger_out) else $error("no refusal");
  reserve_a: assert property (
    start_trigger_set_in && bus_busy_out && !reservation_disable_in &&
    interface_enable_in && !arb_lost_in && !exit_comm_request_in
    |=> start_trigger_out) else $error("no reservation");
  kill_a: assert property (
    exit_comm_request_in || arb_lost_in || !interface_enable_in
    |=> !start_trigger_out) else $error("not killed");
  fire_a: assert property (freed_s |-> ##[1:700]
    (!sda_oe_n_out || !start_trigger_out)) else $error("no auto start");
  restart_a: assert property (rs_cnt_reg != RS_LIM)
    else $error("no restart");
endmodule // start_trig_props
bind start_trig start_trig_props u_props (.ref_clk_in, .rstn_in,
  .start_trigger_set_in, .reservation_disable_in, .exit_comm_request_in,
  .interface_enable_in, .master_wait_in, .wait_release_in, .arb_lost_in,
  .sda_oe_n_out,
  .scl_oe_n_out, .start_trigger_out, .start_clear_flag_out, .bus_busy_out,
  .start_done_out);
`default_nettype wire

// ### tb/far_master.sv
// Foreign master: frames of start, clocked SCL and stop.
// Open-drain outputs; pull-ups are resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module far_master (
  input wire logic hold_in,
  output var logic scl_oe_n_out,
  output var logic sda_oe_n_out
);
  initial begin
    scl_oe_n_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end
  // SCL runs only inside a frame; SDA moves only while SCL is low or idle
  always #40 begin
    sda_oe_n_out <= !(hold_in || !scl_oe_n_out);
    scl_oe_n_out <= (hold_in && !sda_oe_n_out) ? ~scl_oe_n_out : 1'b1;
  end
endmodule // far_master
`default_nettype wire

// ### tb/start_trig_bench.sv
// Testbench for the start trigger block beside a foreign master.
// Bus lines are open drain with pull-ups, resolved here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
  fail_count++; $display("ERROR %s exp %h got %h", n, e, s); end end
module start_trig_bench;
  logic ref_clk_in = 1'b0, rstn_in = 1'b0, start_trigger_set_in = 1'b0;
  logic start_clear_flag_clr_in = 1'b0, reservation_disable_in = 1'b0;
  logic exit_comm_request_in = 1'b0, interface_enable_in = 1'b1;
  logic master_wait_in = 1'b0, wait_release_in = 1'b0, arb_lost_in = 1'b0;
  logic scl_oe_n_out, sda_oe_n_out, start_trigger_out, start_clear_flag_out;
  logic bus_busy_out, start_done_out, wait_state_out, far_scl_n, far_sda_n;
  logic scl_out, sda_out;
  logic far_hold = 1'b0;
  logic [31:0] seed = 32'he7cda881;
  wire logic scl_in = scl_oe_n_out & far_scl_n;
  wire logic sda_in = sda_oe_n_out & far_sda_n;
  int fail_count = 0, checks_done = 0, cycles = 0, i, k;
  always #4 ref_clk_in = ~ref_clk_in;
  start_trig u_start_trig (.ref_clk_in, .rstn_in, .start_trigger_set_in,
    .start_clear_flag_clr_in, .reservation_disable_in, .exit_comm_request_in,
    .interface_enable_in, .master_wait_in, .wait_release_in, .arb_lost_in,
    .scl_in, .sda_in, .scl_out, .scl_oe_n_out, .sda_out, .sda_oe_n_out,
    .start_trigger_out, .start_clear_flag_out, .bus_busy_out,
    .start_done_out, .wait_state_out);
  far_master u_far_master (.hold_in(far_hold), .scl_oe_n_out(far_scl_n),
    .sda_oe_n_out(far_sda_n));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  function automatic logic exp_trig(input logic busy, input logic rdis);
    return !(busy && rdis);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic wait_done(input int lim);
    for (i = 0; i < lim && start_done_out !== 1'b1; i++)
      tick(1);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    tick(4);
    rstn_in = 1'b1;
    `CHK("reset", 2'b01, {start_trigger_out, sda_oe_n_out})
    `CHK("drive low", 2'b00, {scl_out, sda_out})
    seed = xs(seed);
    tick(600 + int'(seed[3:0]));
    far_hold = 1'b1;
    tick(20);
    `CHK("idle sda", 1'b1, sda_oe_n_out)
    `CHK("busy", 1'b1, bus_busy_out)
    reservation_disable_in = 1'b1;
    pulse(start_trigger_set_in);
    `CHK("refused", exp_trig(1'b1, 1'b1), start_trigger_out)
    `CHK("flag", 1'b1, start_clear_flag_out)
    pulse(start_clear_flag_clr_in);
    `CHK("flag clr", 1'b0, start_clear_flag_out)
    reservation_disable_in = 1'b0;
    for (k = 0; k < 2; k++) begin
      pulse(start_trigger_set_in);
      `CHK("reserved", exp_trig(1'b1, 1'b0), start_trigger_out)
      seed = xs(seed);
      tick(1 + int'(seed[2:0]));
      if (k == 0)
        pulse(exit_comm_request_in);
      else
        pulse(arb_lost_in);
      `CHK("killed", 1'b0, start_trigger_out)
    end
    pulse(start_trigger_set_in);
    far_hold = 1'b0;
    wait_done(1500);
    `CHK("auto start", 1'b1, start_done_out)
    `CHK("trig done", 1'b0, start_trigger_out)
    `CHK("wait", 2'b10, {wait_state_out, scl_oe_n_out})
    master_wait_in = 1'b1;
    pulse(start_trigger_set_in);
    pulse(wait_release_in);
    wait_done(1500);
    `CHK("restart", 1'b1, start_done_out)
    master_wait_in = 1'b0;
    pulse(start_trigger_set_in);
    `CHK("set", 1'b1, start_trigger_out)
    interface_enable_in = 1'b0;
    tick(1);
    `CHK("disabled", 1'b0, start_trigger_out)
    `CHK("busy off", 1'b0, bus_busy_out)
    final_report();
  end
endmodule // start_trig_bench
`default_nettype wire
